// >>> uac_core.sv
// asynchronous serial receiver/transmitter core, one line, full or half duplex
//
// Overview of operation
// - receiver and transmitter are independent machines running at the same time
// - each direction has its own x16 bit clock, DC to 160 kHz
// - character length 5, 6, 7 or 8 data bits, shared by both directions
// - optional parity, odd or even, generated on send and checked on receive
// - one or two stop bits; with 5 bit characters one or one and a half
// - both directions buffer a holding stage plus a shift register
// - transmit holding empty is high while a character can be accepted
// - host loads transmit data with a low pulse, captured on its rising edge
// - held character moves to an empty shifter, framing bits added, sending starts
// - end of character rises one sixteenth bit before stop end, until next start
// - receiver looks for a mark to space transition on the line
// - start bit checked at its centre, then each bit sampled at centre
// - character assembled per configured length and parity; stop count ignored on receive
// - parity mismatch raises the parity fault output
// - first stop bit sampled low raises the frame fault output
// - after stop sample: copy to holding, raise ready, latch fault states
// - host drives ready clear low after taking a character; ready drops
// - new character while ready still set raises overrun until the next load
// - short characters are right justified with upper bits low
// - master reset clears all but the line setup, which goes to 8 bits, no parity, one stop; line, end of character, holding empty high
// - line parameters latched into the control register by a control strobe
`timescale 1ns/1ps
`include "uac_defs.svh"

module uac_core #(
	parameter int DATA_WIDTH = `UAC_DATA_WIDTH,
	parameter int FIFO_DEPTH = `UAC_FIFO_DEPTH
) (
	// clock and reset
	input  wire logic                  i_ref_clk,
	input  wire logic                  i_resetn,
	input  wire logic                  i_chip_master_reset,
	// line parameters
	input  wire logic                  i_control_strobe,
	input  wire uac_pkg::uac_cfg_t     i_cfg,
	// bit clocks, sixteen times the baud rate
	input  wire logic                  i_tx_bit_clock16,
	input  wire logic                  i_rx_bit_clock16,
	// transmit host side
	input  wire logic                  i_holding_load_strobe_n,
	input  wire logic [DATA_WIDTH-1:0] i_tx_data,
	output logic                       o_tx_holding_empty,
	// transmit line side
	output logic                       o_tx_line_out,
	output logic                       o_end_of_char,
	// receive line side
	input  wire logic                  i_rx_line_in,
	// receive host side
	input  wire logic                  i_rx_ready_clear_n,
	input  wire logic                  i_status_word_select_n,
	output logic [DATA_WIDTH-1:0]      o_rx_parallel_out,
	output uac_pkg::uac_rx_status_t    o_rx_status,
	output logic [4:0]                 o_status_word
);

	// ************************************************************
	// state, reset value and fifo
	// ************************************************************

	localparam uac_pkg::uac_core_state_t RST_STATE = '{
		cfg:         uac_pkg::uac_cfg_t'(`UAC_CFG_RESET),
		tx_clk_q:    1'b0,
		rx_clk_q:    1'b0,
		strobe_n_q:  1'b1,
		tx_phase:    uac_pkg::TX_IDLE,
		tx_cnt:      6'h00,
		tx_bit:      3'h0,
		tx_sh:       8'h00,
		tx_par:      1'b0,
		tx_line:     `UAC_MARK,
		eoc:         1'b1,
		rx_phase:    uac_pkg::RX_IDLE,
		rx_cnt:      6'h00,
		rx_bit:      3'h0,
		rx_sh:       8'h00,
		rx_si_q:     `UAC_MARK,
		rx_perr:     1'b0,
		rx_hold:     8'h00,
		rx_stat:     '0,
		status_word: 5'h00
	};

	uac_pkg::uac_core_state_t st_r;
	uac_pkg::uac_core_state_t st_nxt;

	logic                  tx_tick;
	logic                  rx_tick;
	logic                  load_push;
	logic                  hold_ready;
	logic                  hold_valid;
	logic [DATA_WIDTH-1:0] hold_data;
	logic                  tx_pop;
	logic                  tx_free;
	logic [5:0]            stop_ticks;
	logic [2:0]            last_bit;
	logic [7:0]            len_mask;
	logic [7:0]            tx_word;

	// the fifo is the transmit holding stage; its ready is holding empty
	uac_fifo #(
		.WIDTH (DATA_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_tx_hold (
		.i_ref_clk   (i_ref_clk),
		.i_resetn    (i_resetn),
		.i_flush     (i_chip_master_reset),
		.i_in_valid  (load_push),
		.i_in_data   (i_tx_data),
		.o_in_ready  (hold_ready),
		.o_out_valid (hold_valid),
		.o_out_data  (hold_data),
		.i_out_ready (tx_pop)
	);

	// ************************************************************
	// next state
	// ************************************************************

	always_comb begin
		st_nxt = st_r;
		tx_pop = 1'b0;

		// bit clocks are plain synchronous inputs; act on their rising edge
		tx_tick = i_tx_bit_clock16 & ~st_r.tx_clk_q;
		rx_tick = i_rx_bit_clock16 & ~st_r.rx_clk_q;
		st_nxt.tx_clk_q = i_tx_bit_clock16;
		st_nxt.rx_clk_q = i_rx_bit_clock16;

		// data is taken on the rising trailing edge of the load strobe
		load_push = ~st_r.strobe_n_q & i_holding_load_strobe_n;
		st_nxt.strobe_n_q = i_holding_load_strobe_n;

		if (i_control_strobe) begin
			st_nxt.cfg = i_cfg;
		end

		// one length setting serves both directions
		last_bit = `UAC_LAST_BIT_BASE + {1'b0, st_r.cfg.len};
		len_mask = 8'hFF >> (2'h3 - st_r.cfg.len);

		if (st_r.cfg.two_stop && st_r.cfg.len == `UAC_LEN_5) begin
			stop_ticks = `UAC_STOP15_TICKS;
		end else if (st_r.cfg.two_stop) begin
			stop_ticks = `UAC_STOP2_TICKS;
		end else begin
			stop_ticks = `UAC_STOP1_TICKS;
		end

		// ********************************************************
		// transmitter
		// ********************************************************

		// shifter counts as empty in its last stop tick, so full speed has no gap
		tx_free = (st_r.tx_phase == uac_pkg::TX_IDLE) ||
			(st_r.tx_phase == uac_pkg::TX_STOP && st_r.tx_cnt == stop_ticks - 6'h01);
		tx_word = 8'(hold_data) & len_mask;

		if (tx_tick && tx_free && hold_valid) begin
			tx_pop = 1'b1;
			st_nxt.tx_sh    = tx_word;
			st_nxt.tx_par   = (^tx_word) ^ st_r.cfg.par_odd;
			st_nxt.tx_line  = `UAC_SPACE;
			st_nxt.eoc      = 1'b0;
			st_nxt.tx_phase = uac_pkg::TX_START;
			st_nxt.tx_cnt   = 6'h00;
			st_nxt.tx_bit   = 3'h0;
		end else if (tx_tick) begin
			case (st_r.tx_phase)
				uac_pkg::TX_START: begin
					if (st_r.tx_cnt == `UAC_BIT_LAST_TICK) begin
						st_nxt.tx_cnt   = 6'h00;
						st_nxt.tx_phase = uac_pkg::TX_DATA;
						st_nxt.tx_line  = st_r.tx_sh[0];
					end else begin
						st_nxt.tx_cnt = st_r.tx_cnt + 6'h01;
					end
				end
				uac_pkg::TX_DATA: begin
					if (st_r.tx_cnt == `UAC_BIT_LAST_TICK) begin
						st_nxt.tx_cnt = 6'h00;
						st_nxt.tx_sh  = {1'b0, st_r.tx_sh[7:1]};
						if (st_r.tx_bit == last_bit && st_r.cfg.par_en) begin
							st_nxt.tx_phase = uac_pkg::TX_PAR;
							// parity of the data sent, flipped for odd sense
							st_nxt.tx_line  = st_r.tx_par;
						end else if (st_r.tx_bit == last_bit) begin
							st_nxt.tx_phase = uac_pkg::TX_STOP;
							st_nxt.tx_line  = `UAC_MARK;
						end else begin
							st_nxt.tx_bit  = st_r.tx_bit + 3'h1;
							st_nxt.tx_line = st_r.tx_sh[1];
						end
					end else begin
						st_nxt.tx_cnt = st_r.tx_cnt + 6'h01;
					end
				end
				uac_pkg::TX_PAR: begin
					if (st_r.tx_cnt == `UAC_BIT_LAST_TICK) begin
						st_nxt.tx_cnt   = 6'h00;
						st_nxt.tx_phase = uac_pkg::TX_STOP;
						st_nxt.tx_line  = `UAC_MARK;
					end else begin
						st_nxt.tx_cnt = st_r.tx_cnt + 6'h01;
					end
				end
				uac_pkg::TX_STOP: begin
					if (st_r.tx_cnt == stop_ticks - 6'h01) begin
						st_nxt.tx_phase = uac_pkg::TX_IDLE;
					end else begin
						st_nxt.tx_cnt = st_r.tx_cnt + 6'h01;
						if (st_r.tx_cnt == stop_ticks - 6'h02) begin
							st_nxt.eoc = 1'b1;
						end
					end
				end
				default: begin
					st_nxt.tx_line = `UAC_MARK;
				end
			endcase
		end

		// ********************************************************
		// receiver
		// ********************************************************

		// host clear is applied first so a character landing now still sets ready
		if (!i_rx_ready_clear_n) begin
			st_nxt.rx_stat.ready = 1'b0;
		end

		// receive half runs on its own tick, never waits on the transmitter
		if (rx_tick) begin
			st_nxt.rx_si_q = i_rx_line_in;
			case (st_r.rx_phase)
				uac_pkg::RX_IDLE: begin
					if (st_r.rx_si_q == `UAC_MARK && i_rx_line_in == `UAC_SPACE) begin
						st_nxt.rx_phase = uac_pkg::RX_START;
						st_nxt.rx_cnt   = 6'h00;
						st_nxt.rx_bit   = 3'h0;
						st_nxt.rx_sh    = 8'h00;
						st_nxt.rx_perr  = 1'b0;
					end
				end
				uac_pkg::RX_START: begin
					// eighth tick after the edge is the centre of the start bit
					if (st_r.rx_cnt == `UAC_START_CHECK && i_rx_line_in == `UAC_SPACE) begin
						st_nxt.rx_phase = uac_pkg::RX_DATA;
						st_nxt.rx_cnt   = 6'h00;
					end else if (st_r.rx_cnt == `UAC_START_CHECK) begin
						st_nxt.rx_phase = uac_pkg::RX_IDLE;
					end else begin
						st_nxt.rx_cnt = st_r.rx_cnt + 6'h01;
					end
				end
				uac_pkg::RX_DATA: begin
					// sixteen ticks on from a centre is the next centre
					if (st_r.rx_cnt == `UAC_BIT_LAST_TICK) begin
						st_nxt.rx_cnt             = 6'h00;
						st_nxt.rx_sh[st_r.rx_bit] = i_rx_line_in;
						if (st_r.rx_bit == last_bit && st_r.cfg.par_en) begin
							st_nxt.rx_phase = uac_pkg::RX_PAR;
						end else if (st_r.rx_bit == last_bit) begin
							st_nxt.rx_phase = uac_pkg::RX_STOP;
						end else begin
							st_nxt.rx_bit = st_r.rx_bit + 3'h1;
						end
					end else begin
						st_nxt.rx_cnt = st_r.rx_cnt + 6'h01;
					end
				end
				uac_pkg::RX_PAR: begin
					if (st_r.rx_cnt == `UAC_BIT_LAST_TICK) begin
						st_nxt.rx_cnt   = 6'h00;
						st_nxt.rx_phase = uac_pkg::RX_STOP;
						// unused upper bits are zero, so the whole word gives the parity
						st_nxt.rx_perr  = i_rx_line_in ^ (^st_r.rx_sh) ^ st_r.cfg.par_odd;
					end else begin
						st_nxt.rx_cnt = st_r.rx_cnt + 6'h01;
					end
				end
				uac_pkg::RX_STOP: begin
					// only the first stop bit is looked at; the rest is idle line
					if (st_r.rx_cnt == `UAC_BIT_LAST_TICK) begin
						st_nxt.rx_phase             = uac_pkg::RX_IDLE;
						st_nxt.rx_hold              = st_r.rx_sh;
						st_nxt.rx_stat.overrun      = st_nxt.rx_stat.ready;
						st_nxt.rx_stat.ready        = 1'b1;
						st_nxt.rx_stat.parity_fault = st_r.rx_perr;
						st_nxt.rx_stat.frame_fault  = ~i_rx_line_in;
					end else begin
						st_nxt.rx_cnt = st_r.rx_cnt + 6'h01;
					end
				end
				default: begin
					st_nxt.rx_phase = uac_pkg::RX_IDLE;
				end
			endcase
		end

		// status word shows only while selected, zero otherwise
		if (!i_status_word_select_n) begin
			st_nxt.status_word = {st_r.rx_stat.parity_fault, st_r.rx_stat.overrun, hold_ready,
				st_r.rx_stat.frame_fault, st_r.rx_stat.ready};
		end else begin
			st_nxt.status_word = 5'h00;
		end

		// master reset beats everything; the fifo is flushed alongside
		if (i_chip_master_reset) begin
			st_nxt = RST_STATE;
			tx_pop = 1'b0;
		end
	end

	// ************************************************************
	// state register and outputs
	// ************************************************************

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_r <= RST_STATE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// every output is a flip-flop; holding empty is the fifo's registered ready
	assign o_tx_holding_empty = hold_ready;
	assign o_tx_line_out      = st_r.tx_line;
	assign o_end_of_char      = st_r.eoc;
	assign o_rx_parallel_out  = DATA_WIDTH'(st_r.rx_hold);
	assign o_rx_status        = st_r.rx_stat;
	assign o_status_word      = st_r.status_word;

endmodule

// >>> uac_defs.svh
// timing, encoding and reset constants of the serial receiver/transmitter core
`ifndef UAC_DEFS_SVH
`define UAC_DEFS_SVH

// character length select codes
`define UAC_LEN_5           2'h0
`define UAC_LEN_8           2'h3

// ticks of the x16 bit clock
`define UAC_TICKS_PER_BIT   6'h10
`define UAC_BIT_LAST_TICK   6'h0F
`define UAC_START_CHECK     6'h07
`define UAC_STOP1_TICKS     6'h10
`define UAC_STOP15_TICKS    6'h18
`define UAC_STOP2_TICKS     6'h20

// index of the last data bit for a five bit character
`define UAC_LAST_BIT_BASE   3'h4

// line levels and reset values
`define UAC_MARK            1'b1
`define UAC_SPACE           1'b0
`define UAC_CFG_RESET       5'h18
`define UAC_DATA_WIDTH      8
`define UAC_FIFO_DEPTH      8

`endif

// >>> uac_pkg.sv
// shared types of the serial receiver/transmitter core
package uac_pkg;

	typedef struct packed {
		logic [1:0] len;
		logic       par_en;
		logic       par_odd;
		logic       two_stop;
	} uac_cfg_t;

	typedef struct packed {
		logic ready;
		logic parity_fault;
		logic frame_fault;
		logic overrun;
	} uac_rx_status_t;

	typedef enum logic [2:0] {
		TX_IDLE  = 3'b000,
		TX_START = 3'b001,
		TX_DATA  = 3'b010,
		TX_PAR   = 3'b011,
		TX_STOP  = 3'b100
	} uac_tx_phase_t;

	typedef enum logic [2:0] {
		RX_IDLE  = 3'b000,
		RX_START = 3'b001,
		RX_DATA  = 3'b010,
		RX_PAR   = 3'b011,
		RX_STOP  = 3'b100
	} uac_rx_phase_t;

	typedef struct packed {
		uac_cfg_t       cfg;
		logic           tx_clk_q;
		logic           rx_clk_q;
		logic           strobe_n_q;
		uac_tx_phase_t  tx_phase;
		logic [5:0]     tx_cnt;
		logic [2:0]     tx_bit;
		logic [7:0]     tx_sh;
		logic           tx_par;
		logic           tx_line;
		logic           eoc;
		uac_rx_phase_t  rx_phase;
		logic [5:0]     rx_cnt;
		logic [2:0]     rx_bit;
		logic [7:0]     rx_sh;
		logic           rx_si_q;
		logic           rx_perr;
		logic [7:0]     rx_hold;
		uac_rx_status_t rx_stat;
		logic [4:0]     status_word;
	} uac_core_state_t;

endpackage

// >>> uac_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps

module uac_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             i_ref_clk,
	input  wire logic             i_resetn,
	input  wire logic             i_flush,
	// fill side
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	// drain side
	output logic                  o_out_valid,
	output logic [WIDTH-1:0]      o_out_data,
	input  wire logic             i_out_ready
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 cnt;
		logic                        rdy;
	} uac_fifo_state_t;

	uac_fifo_state_t st_r;
	uac_fifo_state_t st_nxt;
	logic            push;
	logic            pop;

	always_comb begin
		st_nxt = st_r;
		push   = i_in_valid & st_r.rdy;
		pop    = i_out_ready & (st_r.cnt != '0);
		if (push) begin
			st_nxt.mem[st_r.wp] = i_in_data;
			st_nxt.wp = (st_r.wp == AW'(DEPTH - 1)) ? '0 : st_r.wp + 1'b1;
		end
		if (pop) begin
			st_nxt.rp = (st_r.rp == AW'(DEPTH - 1)) ? '0 : st_r.rp + 1'b1;
		end
		if (push && !pop) begin
			st_nxt.cnt = st_r.cnt + 1'b1;
		end else if (pop && !push) begin
			st_nxt.cnt = st_r.cnt - 1'b1;
		end
		if (i_flush) begin
			st_nxt.wp  = '0;
			st_nxt.rp  = '0;
			st_nxt.cnt = '0;
		end
		// ready is registered so the fill side sees a clean level
		st_nxt.rdy = (st_nxt.cnt != (AW + 1)'(DEPTH));
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_r <= uac_fifo_state_t'{mem: '0, wp: '0, rp: '0, cnt: '0, rdy: 1'b1};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_in_ready  = st_r.rdy;
	assign o_out_valid = (st_r.cnt != '0);
	assign o_out_data  = st_r.mem[st_r.rp];

endmodule

// >>> uac_core_assertions.sv
// port-level checks of the serial core
`timescale 1ns/1ps

module uac_core_checker #(
	parameter int DATA_WIDTH = 8
) (
	// core inputs
	input wire logic                    i_ref_clk,
	input wire logic                    i_resetn,
	input wire logic                    i_chip_master_reset,
	input wire logic                    i_control_strobe,
	input wire uac_pkg::uac_cfg_t       i_cfg,
	input wire logic                    i_tx_bit_clock16,
	input wire logic                    i_rx_bit_clock16,
	input wire logic                    i_holding_load_strobe_n,
	input wire logic [DATA_WIDTH-1:0]   i_tx_data,
	input wire logic                    i_rx_line_in,
	input wire logic                    i_rx_ready_clear_n,
	input wire logic                    i_status_word_select_n,
	// core outputs
	input wire logic                    o_tx_holding_empty,
	input wire logic                    o_tx_line_out,
	input wire logic                    o_end_of_char,
	input wire logic [DATA_WIDTH-1:0]   o_rx_parallel_out,
	input wire uac_pkg::uac_rx_status_t o_rx_status,
	input wire logic [4:0]              o_status_word
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_resetn);

	reset_marks_a:
		assert property ($fell(i_chip_master_reset) |->
			o_tx_line_out && o_end_of_char && o_tx_holding_empty) else $error("reset levels");
	ready_drop_a:
		assert property ($fell(i_rx_ready_clear_n) |-> ##[0:2] !o_rx_status.ready)
		else $error("ready not cleared");
	ready_hold_a:
		assert property (o_rx_status.ready && i_rx_ready_clear_n && $past(i_rx_ready_clear_n)
			&& !i_chip_master_reset |=> o_rx_status.ready) else $error("ready lost");
	eoc_start_a:
		assert property ($fell(o_end_of_char) |-> !o_tx_line_out) else $error("eoc fell early");
	idle_mark_a:
		assert property (o_end_of_char && !$fell(o_tx_line_out) |-> o_tx_line_out)
		else $error("line low while idle");
	load_full_a:
		assert property ($rose(i_holding_load_strobe_n) && o_tx_holding_empty && !o_end_of_char
			|-> ##[1:2] !o_tx_holding_empty) else $error("holding still empty");
	short_char_a:
		assert property ($rose(o_rx_status.ready) && i_cfg.len == 2'h0
			|-> o_rx_parallel_out[7:5] == 3'h0) else $error("upper bits set");
	overrun_cause_a:
		assert property ($rose(o_rx_status.overrun) |-> $past(o_rx_status.ready))
		else $error("overrun without pending");

	cover property ($rose(o_rx_status.ready));
	cover property ($rose(o_rx_status.overrun));
	cover property ($fell(o_end_of_char));
endmodule

// >>> uac_line_model.sv
// remote terminal: drives the receive line, decodes the transmit line
`timescale 1ns/1ps

module uac_line_model (
	// bit clocks shared with the core, and the line from the core
	input  wire logic i_rx_tick,
	input  wire logic i_tx_tick,
	input  wire logic i_line_in,
	// line towards the core
	output logic      o_line_out
);
	initial o_line_out = 1'b1;

	task automatic hold_bit(input logic v, input int n);
		o_line_out = v;
		repeat (n) @(posedge i_rx_tick);
	endtask

	// stop_t in sixteenths of a bit, 24 gives one and a half
	task automatic send(input logic [7:0] d, input int nb, input logic pen, input logic podd,
		input int stop_t, input logic bad_par, input logic stop_lvl);
		int i;
		hold_bit(1'b0, 16);
		for (i = 0; i < nb; i++) hold_bit(d[i], 16);
		if (pen) hold_bit(^d ^ podd ^ bad_par, 16);
		hold_bit(stop_lvl, 16);
		hold_bit(1'b1, stop_t - 16);
	endtask

	// too short to survive the centre sample
	task automatic glitch();
		hold_bit(1'b0, 4);
		hold_bit(1'b1, 32);
	endtask

	task automatic capture(output logic [7:0] d, output logic p, input int nb, input logic pen);
		int i;
		d = 8'h00;
		p = 1'b0;
		@(negedge i_line_in);
		repeat (8) @(posedge i_tx_tick);
		for (i = 0; i < nb; i++) begin
			repeat (16) @(posedge i_tx_tick);
			d[i] = i_line_in;
		end
		if (pen) begin
			repeat (16) @(posedge i_tx_tick);
			p = i_line_in;
		end
		repeat (16) @(posedge i_tx_tick);
	endtask
endmodule

// >>> tb_top.sv
// self-checking bench of the serial core
`timescale 1ns/1ps

module tb_top;
	logic                    i_ref_clk, i_resetn, mrst, cs, ld_n, clr_n, line_rx, tx_holding_empty, line_tx, eoc;
	logic [1:0]              rdiv;
	logic [2:0]              tdiv;
	logic [7:0]              txd, rxq, cd, cd2;
	logic [4:0]              sw;
	logic                    cp, cp2;
	logic                    sws;
	uac_pkg::uac_cfg_t       cfg;
	uac_pkg::uac_rx_status_t st;
	int                      n_fail, checks_done, cyc, i;
	// rows: line setup, character, parity bit on the wire
	logic [13:0] rows [6] = '{14'h002A, 14'h1C54, 14'h2AB8, 14'h334A, 14'h3907, 14'h0E3E};
	wire rxc = rdiv[1];
	wire txc = (tdiv > 3'h2);

	// one deep holding stage, as a single holding register
	uac_core #(.FIFO_DEPTH(1)) u_uac_core (
		.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_chip_master_reset(mrst),
		.i_control_strobe(cs), .i_cfg(cfg), .i_tx_bit_clock16(txc), .i_rx_bit_clock16(rxc),
		.i_holding_load_strobe_n(ld_n), .i_tx_data(txd), .o_tx_holding_empty(tx_holding_empty),
		.o_tx_line_out(line_tx), .o_end_of_char(eoc), .i_rx_line_in(line_rx),
		.i_rx_ready_clear_n(clr_n), .i_status_word_select_n(sws), .o_rx_parallel_out(rxq),
		.o_rx_status(st), .o_status_word(sw));
	uac_line_model u_uac_line_model (.i_rx_tick(rxc), .i_tx_tick(txc), .i_line_in(line_tx),
		.o_line_out(line_rx));

	initial begin
		i_ref_clk = 1'b0;
		rdiv = 2'h0;
		tdiv = 3'h0;
		cyc = 0;
		forever #4 i_ref_clk = ~i_ref_clk;
	end

	// unrelated tick rates keep the two halves out of step
	always @(posedge i_ref_clk) begin
		rdiv <= rdiv + 2'h1;
		tdiv <= (tdiv == 3'h5) ? 3'h0 : tdiv + 3'h1;
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_fail++;
			end_of_test();
		end
	end

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask

	task automatic set_cfg(input logic [4:0] c);
		cfg = c;
		cs = 1'b1;
		tick(1);
		cs = 1'b0;
		tick(1);
	endtask

	task automatic load(input logic [7:0] d);
		int n;
		for (n = 0; n < 5000 && tx_holding_empty !== 1'b1; n++) tick(1);
		txd = d;
		ld_n = 1'b0;
		tick(1);
		ld_n = 1'b1;
		tick(1);
	endtask

	task automatic rx(input logic [7:0] d, input logic bad_par, input logic stop_lvl);
		u_uac_line_model.send(d, cfg.len + 5, cfg.par_en, cfg.par_odd,
			cfg.two_stop ? (cfg.len == 2'h0 ? 24 : 32) : 16, bad_par, stop_lvl);
		tick(1);
	endtask

	task automatic clear_ready();
		clr_n = 1'b0;
		tick(1);
		clr_n = 1'b1;
		tick(2);
		chk("ready_clr", {7'h00, st.ready}, 8'h00);
	endtask

	// ****************
	// main sequence
	// ****************
	initial begin
		i_resetn = 1'b0;
		mrst = 1'b0;
		cs = 1'b0;
		ld_n = 1'b1;
		clr_n = 1'b1;
		sws = 1'b1;
		txd = 8'h00;
		cfg = 5'h00;
		n_fail = 0;
		checks_done = 0;
		tick(20);
		i_resetn = 1'b1;
		mrst = 1'b1;
		tick(2);
		mrst = 1'b0;
		tick(2);
		chk("idle", {5'h00, line_tx, eoc, tx_holding_empty}, 8'h07);
		for (i = 0; i < 6; i++) begin
			set_cfg(rows[i][13:9]);
			fork
				u_uac_line_model.capture(cd, cp, rows[i][13:12] + 5, rows[i][11]);
				load(rows[i][8:1]);
				rx(rows[i][8:1], 1'b0, 1'b1);
			join
			chk("tx_data", cd, rows[i][8:1]);
			if (rows[i][11]) chk("tx_par", {7'h00, cp}, {7'h00, rows[i][0]});
			chk("rx_data", rxq, rows[i][8:1]);
			chk("rx_stat", {4'h0, st}, 8'h08);
			clear_ready();
		end
		set_cfg(5'h0E);
		rx(8'h2A, 1'b1, 1'b1);
		chk("par_fault", {4'h0, st}, 8'h0C);
		clear_ready();
		rx(8'h15, 1'b0, 1'b0);
		chk("frame", {4'h0, st}, 8'h0A);
		clear_ready();
		rx(8'h11, 1'b0, 1'b1);
		rx(8'h22, 1'b0, 1'b1);
		chk("ovr_data", rxq, 8'h22);
		chk("ovr_stat", {4'h0, st}, 8'h09);
		sws = 1'b0;
		tick(2);
		chk("stat_word", {3'h0, sw}, 8'h0D);
		sws = 1'b1;
		clear_ready();
		rx(8'h33, 1'b0, 1'b1);
		chk("ovr_gone", {4'h0, st}, 8'h08);
		clear_ready();
		u_uac_line_model.glitch();
		chk("noise", {4'h0, st}, 8'h00);
		set_cfg(5'h19);
		fork
			begin
				u_uac_line_model.capture(cd, cp, 8, 1'b0);
				u_uac_line_model.capture(cd2, cp2, 8, 1'b0);
			end
			begin
				load(8'hC3);
				load(8'h3C);
				tick(2);
				chk("tx_holding_empty_full", {7'h00, tx_holding_empty}, 8'h00);
			end
		join
		chk("b2b_one", cd, 8'hC3);
		chk("b2b_two", cd2, 8'h3C);
		load(8'h00);
		tick(300);
		mrst = 1'b1;
		tick(2);
		mrst = 1'b0;
		tick(1);
		chk("mreset", {5'h00, line_tx, eoc, tx_holding_empty}, 8'h07);
		end_of_test();
	end
endmodule

bind uac_core uac_core_checker #(.DATA_WIDTH(DATA_WIDTH)) u_uac_core_checker (
	.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_chip_master_reset(i_chip_master_reset),
	.i_control_strobe(i_control_strobe), .i_cfg(i_cfg), .i_tx_bit_clock16(i_tx_bit_clock16),
	.i_rx_bit_clock16(i_rx_bit_clock16), .i_holding_load_strobe_n(i_holding_load_strobe_n),
	.i_tx_data(i_tx_data), .i_rx_line_in(i_rx_line_in), .i_rx_ready_clear_n(i_rx_ready_clear_n),
	.i_status_word_select_n(i_status_word_select_n), .o_tx_holding_empty(o_tx_holding_empty),
	.o_tx_line_out(o_tx_line_out), .o_end_of_char(o_end_of_char),
	.o_rx_parallel_out(o_rx_parallel_out), .o_rx_status(o_rx_status),
	.o_status_word(o_status_word));
